// >>> pcm_map.svh
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// register byte offsets
`define PCM_PLLCFG_OFS    8'h00
`define PCM_OSCCFG_OFS    8'h04
`define PCM_SYSCFG_OFS    8'h08
`define PCM_STAT_OFS      8'h0c

// pll config field positions
`define PCM_BYP_POS       0
`define PCM_DISC_POS      1
`define PCM_NDIV_LSB      2
`define PCM_K2_LSB        6
`define PCM_K1_POS        8
`define PCM_VCO_RANGE_SEL_POS    9
`define PCM_SLEEP_POS     10
`define PCM_LOCK_POS      12
`define PCM_PLLCFG_W      11

// osc config field positions
`define PCM_OSC_SOURCE_SEL_LSB     0
`define PCM_OSCLOW_POS    2

// status field positions
`define PCM_ST_NORM_POS   0
`define PCM_ST_PRESC_POS  1
`define PCM_ST_FREE_POS   2
`define PCM_ST_LOCK_POS   3
`define PCM_ST_SRC_LSB    4
`define PCM_ST_START_POS  6
`define PCM_ST_SLEEP_POS  7

// reset values
`define PCM_PLLCFG_RST    11'h0a0
`define PCM_OSC_SOURCE_SEL_RST     2'h0
`define PCM_SYSSEL_RST    2'h0

// source rates and clock rate
`define PCM_CLK_MHZ       100
`define PCM_INT_OSC_MHZ   5
`define PCM_RC_MHZ        18
`define PCM_INT_STEP      (2 * `PCM_INT_OSC_MHZ)
`define PCM_RC_STEP       (2 * `PCM_RC_MHZ)
`define PCM_ACC_MOD       `PCM_CLK_MHZ

// divider and reference source encodings
`define PCM_K2_BASE       5'h02
`define PCM_EXT_SRC       2'h1

`endif

// >>> pcm_pkg.sv
package pcm_pkg;

	typedef enum logic [1:0] {
		PCM_MODE_NORMAL = 2'b00,
		PCM_MODE_PRESC  = 2'b01,
		PCM_MODE_FREE   = 2'b10
	} pcm_mode_e;

	typedef enum logic [1:0] {
		PCM_SRC_RC  = 2'b00,
		PCM_SRC_OSC = 2'b01,
		PCM_SRC_PLL = 2'b10
	} pcm_src_e;

	// bit order matches the pll config register, lsb last
	typedef struct packed {
		logic       sleep;
		logic       vcoRange;
		logic       k1;
		logic [1:0] k2;
		logic [3:0] nDiv;
		logic       disc;
		logic       byp;
	} pcm_pll_cfg_s;

	typedef struct packed {
		logic wakeSeq;
		logic powerSave;
		logic oscLow;
		logic lock;
		logic vco;
		logic extOsc;
	} pcm_pins_s;

endpackage : pcm_pkg

// >>> pcm_clock_ctrl.sv
// Functional notes
// - system clock from pll, oscillator or rc
// - rc startup clock 18 MHz, not configurable
// - pll reference is internal or external oscillator
// - bypass and disconnect bits decode pll mode
// - normal mode output is reference times N/(P*K2)
// - normal reported when bypass 0, disconnect 0, locked
// - prescaler output is reference divided by K1
// - prescaler needs oscillator ok when external reference
// - free-running output is vco base over K2
// - three conditions lead into free-running mode
// - free-running reported when bypass 0, disconnect 1, unlocked
// - input divider P fixed at one
// - feedback divider N is four-bit field
// - two-bit K2 and one-bit K1 fields
// - divider and mode switches are glitchless
// - pll sleeps on request and during power-save
// - vco range 48 to 160 MHz by select
// - internal 5 MHz oscillator as reference source
// - free-running uses vco frequency without reference
//
// The register addresses and register access over Wishbone were left to the implementer.
`include "pcm_map.svh"

module pcm_clock_ctrl
	import pcm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic        extOscPin,
	input  wire logic        vcoPin,
	input  wire logic        lockPin,
	input  wire logic        oscTooLowPin,
	input  wire logic        powerSavePin,
	input  wire logic        wakeSeqPin,
	output logic             sysClk,
	output logic             pllClk,
	output logic             fbClk,
	output logic             refClk,
	output logic             pllSleep,
	output logic             vcoRangeSel
);

	logic [1:0]   rstPipe_q;
	logic         rstSync_n;
	pcm_pins_s    pinS1_q;
	pcm_pins_s    pinS2_q;
	pcm_pins_s    pinS3_q;
	logic         extEdge;
	logic         vcoEdge;
	logic [6:0]   intAcc_q;
	logic         intLvl_q;
	logic         intTick_q;
	logic [7:0]   rcAcc_q;
	logic         rcLvl_q;
	pcm_pll_cfg_s pllCfg_q;
	logic [1:0]   oscSrc_q;
	pcm_src_e     swSel_q;
	logic         startup_q;
	logic         refIsExt;
	logic         refTick;
	logic         refLvl;
	pcm_mode_e    modeD;
	logic         normAct;
	logic         prescAct;
	logic         freeAct;
	logic [4:0]   nDiv;
	logic [4:0]   k1Div;
	logic [4:0]   k2Div;
	logic [4:0]   newDiv;
	logic [4:0]   fbCnt_q;
	logic         fbClk_q;
	pcm_mode_e    curMode_q;
	logic [4:0]   curDiv_q;
	logic [4:0]   pllCnt_q;
	logic         pllClk_q;
	logic         pllTick;
	logic         sleepReq;
	logic         pllSleep_q;
	logic         refClk_q;
	logic         vcoRange_q;
	pcm_src_e     reqSel;
	pcm_src_e     sysSel_q;
	logic         sysClk_q;
	logic         curLvl;
	logic         reqLvl;
	logic         wbReq;
	logic         ack_q;
	logic [31:0]  rdat_q;
	logic [31:0]  wMask;
	logic [31:0]  rdMux;
	logic [31:0]  pllImg;
	logic [31:0]  pllNew;
	logic [31:0]  oscImg;
	logic [31:0]  oscNew;
	logic [31:0]  sysImg;
	logic [31:0]  sysNew;
	logic [31:0]  statImg;
	logic         wrPll;
	logic         wrOsc;
	logic         wrSys;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe_q[1];

	// pins come from other domains; stage three only for edges
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinS1_q <= '0;
			pinS2_q <= '0;
			pinS3_q <= '0;
		end else begin
			pinS1_q <= {wakeSeqPin, powerSavePin, oscTooLowPin,
				lockPin, vcoPin, extOscPin};
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
		end
	end
	// both edges count, so a divide by one still gives a clean wave
	assign extEdge = pinS2_q.extOsc ^ pinS3_q.extOsc;
	assign vcoEdge = pinS2_q.vco ^ pinS3_q.vco;

	// internal reference oscillator as a fractional rate enable
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			intAcc_q  <= 7'h00;
			intLvl_q  <= 1'b0;
			intTick_q <= 1'b0;
		end else if (intAcc_q + 7'(`PCM_INT_STEP) >= 7'(`PCM_ACC_MOD)) begin
			intAcc_q  <= intAcc_q + 7'(`PCM_INT_STEP) - 7'(`PCM_ACC_MOD);
			intLvl_q  <= ~intLvl_q;
			intTick_q <= 1'b1;
		end else begin
			intAcc_q  <= intAcc_q + 7'(`PCM_INT_STEP);
			intTick_q <= 1'b0;
		end
	end

	// rc startup clock, fixed rate with no software knob
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rcAcc_q <= 8'h00;
			rcLvl_q <= 1'b0;
		end else if (rcAcc_q + 8'(`PCM_RC_STEP) >= 8'(`PCM_ACC_MOD)) begin
			rcAcc_q <= rcAcc_q + 8'(`PCM_RC_STEP) - 8'(`PCM_ACC_MOD);
			rcLvl_q <= ~rcLvl_q;
		end else begin
			rcAcc_q <= rcAcc_q + 8'(`PCM_RC_STEP);
		end
	end

	// reference selection
	assign refIsExt = (oscSrc_q == `PCM_EXT_SRC);
	assign refTick  = refIsExt ? extEdge : intTick_q;
	assign refLvl   = refIsExt ? pinS2_q.extOsc : intLvl_q;

	// mode decode, external oscillator loss in bypass forces free-running
	always_comb begin
		modeD = PCM_MODE_NORMAL;
		if (pllCfg_q.byp) begin
			if (refIsExt && pinS2_q.oscLow) begin
				modeD = PCM_MODE_FREE;
			end else begin
				modeD = PCM_MODE_PRESC;
			end
		end else if (pllCfg_q.disc || !pinS2_q.lock) begin
			modeD = PCM_MODE_FREE;
		end
	end

	assign normAct  = !pllCfg_q.byp && !pllCfg_q.disc
		&& pinS2_q.lock;
	assign prescAct = pllCfg_q.byp
		&& !(refIsExt && pinS2_q.oscLow);
	assign freeAct  = !pllCfg_q.byp && pllCfg_q.disc
		&& !pinS2_q.lock;

	// divisor decode; P is one, so no input divider exists
	assign nDiv  = (pllCfg_q.nDiv == 4'h0) ? 5'h10
		: {1'b0, pllCfg_q.nDiv};
	assign k2Div = {3'h0, pllCfg_q.k2} + `PCM_K2_BASE;
	assign k1Div = pllCfg_q.k1 ? 5'h02 : 5'h01;
	assign newDiv = (modeD == PCM_MODE_PRESC) ? k1Div : k2Div;

	// feedback divider output for the phase detector
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			fbCnt_q <= 5'h00;
			fbClk_q <= 1'b0;
		end else if (pllSleep_q) begin
			fbCnt_q <= 5'h00;
			fbClk_q <= 1'b0;
		end else if (vcoEdge) begin
			if (fbCnt_q + 5'h01 >= nDiv) begin
				fbCnt_q <= 5'h00;
				fbClk_q <= ~fbClk_q;
			end else begin
				fbCnt_q <= fbCnt_q + 5'h01;
			end
		end
	end

	// reference level forwarded to the analog phase detector
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			refClk_q <= 1'b0;
		end else begin
			refClk_q <= refLvl & ~pllSleep_q;
		end
	end

	// normal and free-running both divide vco edges by K2; locked
	// the vco runs at ref*N, unlocked it runs at its base rate
	assign pllTick = (curMode_q == PCM_MODE_PRESC) ? refTick
		: vcoEdge;

	// new mode and divisor load at a falling edge of the output
	// or during sleep, so a switch never cuts a high phase short
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			curMode_q <= PCM_MODE_NORMAL;
			curDiv_q  <= `PCM_K2_BASE;
			pllCnt_q  <= 5'h00;
			pllClk_q  <= 1'b0;
		end else if (pllSleep_q) begin
			curMode_q <= modeD;
			curDiv_q  <= newDiv;
			pllCnt_q  <= 5'h00;
			pllClk_q  <= 1'b0;
		end else if (pllTick) begin
			if (pllCnt_q + 5'h01 >= curDiv_q) begin
				pllCnt_q <= 5'h00;
				pllClk_q <= ~pllClk_q;
				if (pllClk_q) begin
					curMode_q <= modeD;
					curDiv_q  <= newDiv;
				end
			end else begin
				pllCnt_q <= pllCnt_q + 5'h01;
			end
		end
	end

	// sleep follows the bit or power-save without software help
	assign sleepReq = pllCfg_q.sleep | pinS2_q.powerSave;
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pllSleep_q <= 1'b0;
			vcoRange_q <= 1'b0;
		end else begin
			pllSleep_q <= sleepReq;
			vcoRange_q <= pllCfg_q.vcoRange;
		end
	end

	// rc clock forced during startup and the wake-up sequence
	always_comb begin
		reqSel = swSel_q;
		if (startup_q || pinS2_q.wakeSeq) begin
			reqSel = PCM_SRC_RC;
		end
	end

	always_comb begin
		unique case (sysSel_q)
			PCM_SRC_RC:  curLvl = rcLvl_q;
			PCM_SRC_OSC: curLvl = pinS2_q.extOsc;
			PCM_SRC_PLL: curLvl = pllClk_q;
			default:     curLvl = rcLvl_q;
		endcase
	end

	always_comb begin
		unique case (reqSel)
			PCM_SRC_RC:  reqLvl = rcLvl_q;
			PCM_SRC_OSC: reqLvl = pinS2_q.extOsc;
			PCM_SRC_PLL: reqLvl = pllClk_q;
			default:     reqLvl = rcLvl_q;
		endcase
	end

	// switch once output is low too, so no high phase is cut short
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sysSel_q <= PCM_SRC_RC;
			sysClk_q <= 1'b0;
		end else begin
			if (reqSel != sysSel_q && !sysClk_q && !curLvl && !reqLvl) begin
				sysSel_q <= reqSel;
				sysClk_q <= 1'b0;
			end else begin
				sysClk_q <= curLvl;
			end
		end
	end

	// startup phase ends on the first source selection write
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			startup_q <= 1'b1;
		end else if (wrSys) begin
			startup_q <= 1'b0;
		end
	end

	// wishbone slave, one wait state, unmapped reads return zero
	assign wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wrPll = wbReq & wb_we_i & (wb_adr_i == `PCM_PLLCFG_OFS);
	assign wrOsc = wbReq & wb_we_i & (wb_adr_i == `PCM_OSCCFG_OFS);
	assign wrSys = wbReq & wb_we_i & (wb_adr_i == `PCM_SYSCFG_OFS);

	always_comb begin
		pllImg = 32'h0;
		pllImg[`PCM_PLLCFG_W-1:0] = pllCfg_q;
		pllImg[`PCM_LOCK_POS] = pinS2_q.lock;
		oscImg = 32'h0;
		oscImg[`PCM_OSC_SOURCE_SEL_LSB +: 2] = oscSrc_q;
		oscImg[`PCM_OSCLOW_POS] = pinS2_q.oscLow;
		sysImg = 32'h0;
		sysImg[1:0] = swSel_q;
		statImg = 32'h0;
		statImg[`PCM_ST_NORM_POS]  = normAct;
		statImg[`PCM_ST_PRESC_POS] = prescAct;
		statImg[`PCM_ST_FREE_POS]  = freeAct;
		statImg[`PCM_ST_LOCK_POS]  = pinS2_q.lock;
		statImg[`PCM_ST_SRC_LSB +: 2] = sysSel_q;
		statImg[`PCM_ST_START_POS] = startup_q;
		statImg[`PCM_ST_SLEEP_POS] = pllSleep_q;
		pllNew = (pllImg & ~wMask) | (wb_dat_i & wMask);
		oscNew = (oscImg & ~wMask) | (wb_dat_i & wMask);
		sysNew = (sysImg & ~wMask) | (wb_dat_i & wMask);
	end

	always_comb begin
		unique case (wb_adr_i)
			`PCM_PLLCFG_OFS: rdMux = pllImg;
			`PCM_OSCCFG_OFS: rdMux = oscImg;
			`PCM_SYSCFG_OFS: rdMux = sysImg;
			`PCM_STAT_OFS:   rdMux = statImg;
			default:         rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= wbReq;
			rdat_q <= wbReq ? rdMux : 32'h0;
		end
	end

	// lock and oscillator-low bits are never stored from writes
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pllCfg_q <= `PCM_PLLCFG_RST;
		end else if (wrPll) begin
			pllCfg_q <= pllNew[`PCM_PLLCFG_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			oscSrc_q <= `PCM_OSC_SOURCE_SEL_RST;
		end else if (wrOsc) begin
			oscSrc_q <= oscNew[`PCM_OSC_SOURCE_SEL_LSB +: 2];
		end
	end

	// the unused code 3 is kept as rc so software cannot stall
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			swSel_q <= pcm_src_e'(`PCM_SYSSEL_RST);
		end else if (wrSys) begin
			swSel_q <= (sysNew[1:0] == 2'h3) ? PCM_SRC_RC
				: pcm_src_e'(sysNew[1:0]);
		end
	end

	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = rdat_q;
	assign sysClk      = sysClk_q;
	assign pllClk      = pllClk_q;
	assign fbClk       = fbClk_q;
	assign refClk      = refClk_q;
	assign pllSleep    = pllSleep_q;
	assign vcoRangeSel = vcoRange_q;

endmodule // pcm_clock_ctrl

// >>> pcm_clock_ctrl_monitor.sv
module pcm_clock_ctrl_monitor
	import pcm_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        powerSavePin,
	input wire logic        sysClk,
	input wire logic        pllClk,
	input wire logic        fbClk,
	input wire logic        refClk,
	input wire logic        pllSleep,
	input wire logic        vcoRangeSel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req;
	logic vcoExp_q;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// remember the written range bit, the master drops data after ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) vcoExp_q <= 1'b0;
		else if (req) vcoExp_q <= wb_dat_i[9];
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_LATENCY: assert property (req |=> wb_ack_o)
		else $error("request not acknowledged");
	AST_DAT_IDLE_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	AST_PS_SLEEP: assert property (powerSavePin [*8] |-> pllSleep)
		else $error("no sleep in power save");
	AST_SLEEP_QUIET: assert property (pllSleep [*3] |->
		!pllClk && !fbClk && !refClk)
		else $error("pll clocks run in sleep");
	AST_PLL_NO_RUNT: assert property ($rose(pllClk) |=> pllClk || pllSleep)
		else $error("short pll pulse");
	AST_SYS_NO_RUNT: assert property ($fell(sysClk) |=> !sysClk)
		else $error("short system clock low");
	AST_VCO_SEL: assert property (req && wb_we_i && wb_adr_i == 8'h00
		&& wb_sel_i[1] |-> ##[1:3] vcoRangeSel == vcoExp_q)
		else $error("range select not updated");
endmodule // pcm_clock_ctrl_monitor

bind pcm_clock_ctrl pcm_clock_ctrl_monitor mon_u (.clk, .rst_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o,
	.wb_dat_o, .powerSavePin, .sysClk, .pllClk, .fbClk, .refClk, .pllSleep,
	.vcoRangeSel);

// >>> tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hf;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        extOscPin = 1'b0;
	logic        vcoPin = 1'b0;
	logic        lockPin = 1'b0;
	logic        oscTooLowPin = 1'b0;
	logic        powerSavePin = 1'b0;
	logic        wakeSeqPin = 1'b0;
	logic        sysClk, pllClk, fbClk, refClk, pllSleep, vcoRangeSel;
	logic [1:0]  extCnt = 2'h0;
	logic [31:0] q;
	logic        pv;
	int          n_fail = 0;
	int          comparisons = 0;
	int          i, k, nf;

	pcm_clock_ctrl dut_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_dat_o, .extOscPin,
		.vcoPin, .lockPin, .oscTooLowPin, .powerSavePin, .wakeSeqPin,
		.sysClk, .pllClk, .fbClk, .refClk, .pllSleep, .vcoRangeSel);

	always #5 clk = ~clk;
	// vco edge every cycle, external oscillator level every 3 cycles
	always @(posedge clk) begin
		vcoPin <= ~vcoPin;
		extCnt <= (extCnt == 2'h2) ? 2'h0 : extCnt + 2'h1;
		if (extCnt == 2'h2) extOscPin <= ~extOscPin;
	end

	task automatic stop_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 40);
		if (t >= 40) chk(32'h0, 32'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return sysClk;
			1: return pllClk;
			2: return fbClk;
			default: return refClk;
		endcase
	endfunction

	function automatic logic [2:0] modeExp(input logic [4:0] v);
		return {!v[0] && v[1] && !v[2], v[0] && !(v[3] && v[4]),
			!v[0] && !v[1] && v[2]};
	endfunction

	// settle long enough for a divisor to load at a falling edge
	task automatic per(input int s, input int exp);
		int t, c, n;
		t = 0;
		c = 0;
		n = 0;
		repeat (100) @(posedge clk);
		pv = pick(s);
		while (c < 2 && t < 500) begin
			@(posedge clk);
			t++;
			if (c == 1) n++;
			if (pick(s) === 1'b1 && pv === 1'b0) c++;
			pv = pick(s);
		end
		chk(n, exp);
	endtask

	initial begin
		repeat (50000) @(posedge clk);
		n_fail++;
		stop_test();
	end

	initial begin
		void'($urandom(32'hda4d));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, 8'h00, 32'h0, 4'hf);
		chk(q, 32'h0a0);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		chk(q, 32'h40);
		bus(1'b1, 8'h20, 32'hffff, 4'hf);
		bus(1'b0, 8'h20, 32'h0, 4'hf);
		chk(q, 32'h0);
		for (i = 0; i < 32; i++) begin
			lockPin <= i[2];
			oscTooLowPin <= i[4];
			k = $urandom & 32'h3fc;
			bus(1'b1, 8'h00, k | 32'h1000 | i[1:0], 4'hf);
			bus(1'b1, 8'h04, {29'h0, 1'b1, i[3] ? 2'h1 : 2'h2}, 4'hf);
			repeat (4) @(posedge clk);
			bus(1'b0, 8'h00, 32'h0, 4'hf);
			chk(q, k | i[1:0] | {19'h0, i[2], 12'h0});
			bus(1'b0, 8'h04, 32'h0, 4'hf);
			chk(q, {i[4], i[3] ? 2'h1 : 2'h2});
			bus(1'b0, 8'h0c, 32'h0, 4'hf);
			chk(q[2:0], modeExp(i[4:0]));
		end
		lockPin <= 1'b1;
		oscTooLowPin <= 1'b0;
		for (k = 0; k < 4; k++) begin
			nf = $urandom_range(15);
			bus(1'b1, 8'h00, (nf << 2) | (k << 6), 4'hf);
			per(1, 2 * (k + 2));
			per(2, 2 * (nf == 0 ? 16 : nf));
		end
		bus(1'b1, 8'h00, 32'h42, 4'hf);
		per(1, 6);
		bus(1'b1, 8'h04, 32'h0, 4'hf);
		for (k = 0; k < 2; k++) begin
			bus(1'b1, 8'h00, 32'h1 | (k << 8), 4'hf);
			per(1, 20 * (k + 1));
			per(3, 20);
		end
		bus(1'b1, 8'h04, 32'h1, 4'hf);
		per(3, 6);
		per(1, 12);
		bus(1'b1, 8'h00, 32'h10, 4'hf);
		bus(1'b1, 8'h08, 32'h2, 4'hf);
		per(0, 4);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		chk(q, 32'h29);
		wakeSeqPin <= 1'b1;
		repeat (20) @(posedge clk);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		chk(q[5:4], 2'h0);
		wakeSeqPin <= 1'b0;
		bus(1'b1, 8'h08, 32'h1, 4'hf);
		per(0, 6);
		bus(1'b1, 8'h08, 32'h3, 4'hf);
		bus(1'b0, 8'h08, 32'h0, 4'hf);
		chk(q, 32'h0);
		repeat (20) @(posedge clk);
		nf = 0;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk);
			if (sysClk === 1'b1 && pv === 1'b0) nf++;
			pv = sysClk;
		end
		chk(nf >= 179 && nf <= 181, 1'b1);
		powerSavePin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pllSleep, 1'b1);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		chk(q[7], 1'b1);
		powerSavePin <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pllSleep, 1'b0);
		bus(1'b1, 8'h00, 32'h400, 4'hf);
		repeat (3) @(posedge clk);
		chk(pllSleep, 1'b1);
		bus(1'b1, 8'h00, 32'h200, 4'h1);
		repeat (2) @(posedge clk);
		chk(vcoRangeSel, 1'b0);
		bus(1'b1, 8'h00, 32'h200, 4'h2);
		repeat (2) @(posedge clk);
		chk(vcoRangeSel, 1'b1);
		stop_test();
	end
endmodule // tb
